// File: rtl/qr_valley_skip_softstart.sv
// Valley-skip counter, zero-crossing counter, switch timing and soft-start
// Assumes comparator inputs already synchronous to clk
//
// Summary of operation
// - Keep a valley-skip count of crossings passed over before switch-on.
// - Evaluate feedback thresholds once per 48 ms update period, then adjust.
// - Feedback always below count-up threshold: increment, saturating at 7.
// - Above count-up but never above count-down threshold: hold count.
// - Above count-down but never above preset threshold: decrement, floor 1.
// - Feedback above preset threshold forces count to 1 at once.
// - Count always stays within 1 to 7 inclusive.
// - Count loads 1 at start-up.
// - Count-up and count-down thresholds shift with sensed line level.
// - Supply above turn-on threshold stops charging source, starts soft-start.
// - Soft-start lasts 12 ms in four equal steps.
// - Peak limit rises stepwise from 0.32 V to 1 V.
// - Switch-on from crossings and count, switch-off from feedback vs current.
// - Ringing suppression timer blocks false switch-on after switch-off.
// - Crossing count 0..7 increments per falling crossing, clears at gate on.
// - After suppression, switch on when crossing count reaches skip count.
// - After maximum off interval, switch on regardless.
`timescale 1ns/1ns
module qr_valley_skip_softstart #(
  parameter int unsigned UPDATE_CYCLES = qr_pkg::UPDATE_CYCLES,
  parameter int unsigned STEP_CYCLES   = qr_pkg::STEP_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       supply_turn_on_threshold,
  input  wire logic       line_high,
  input  wire logic       fb_above_up_lo,
  input  wire logic       fb_above_up_hi,
  input  wire logic       fb_above_down_lo,
  input  wire logic       fb_above_down_hi,
  input  wire logic       fb_above_preset,
  input  wire logic       zero_cross_input,
  input  wire logic       zc_above_ring_level,
  input  wire logic       cs_above_feedback,
  output logic            gate_on,
  output logic            charge_enable,
  output logic [1:0]      peak_limit_step,
  output logic [2:0]      skip_count,
  output logic [2:0]      zc_count
);
  localparam int unsigned UW = $clog2(UPDATE_CYCLES + 1);
  localparam int unsigned SW = $clog2(STEP_CYCLES + 1);
  localparam int unsigned OW = $clog2(qr_pkg::OFF_MAX_CYC + 1);

  qr_pkg::phase_e phase_reg;
  logic [UW-1:0]  upd_cnt_reg;
  logic [SW-1:0]  step_cnt_reg;
  logic [OW-1:0]  off_cnt_reg;
  logic [OW-1:0]  ring_cnt_reg;
  logic           seen_up_reg;
  logic           seen_down_reg;
  logic           zc_prev_reg;
  logic           period_end;
  logic           above_up;
  logic           above_down;
  logic           zc_fall;
  logic           ring_done;
  logic           turn_on;
  logic           running;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up phase and soft-start
  assign running = (phase_reg != qr_pkg::ST_WAIT);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg     <= qr_pkg::ST_WAIT;
      charge_enable <= 1'b1;
    end
    else if (phase_reg == qr_pkg::ST_WAIT && supply_turn_on_threshold)
    begin
      phase_reg     <= qr_pkg::ST_SOFT;
      charge_enable <= 1'b0;
    end
    else if (phase_reg == qr_pkg::ST_SOFT && peak_limit_step == qr_pkg::LIMIT_FINAL &&
             step_cnt_reg == SW'(STEP_CYCLES - 1))
    begin
      phase_reg <= qr_pkg::ST_RUN;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_cnt_reg    <= '0;
      peak_limit_step <= 2'h0;
    end
    else if (phase_reg == qr_pkg::ST_SOFT)
    begin
      if (step_cnt_reg == SW'(STEP_CYCLES - 1))
      begin
        step_cnt_reg <= '0;
        if (peak_limit_step != qr_pkg::LIMIT_FINAL)
        begin
          peak_limit_step <= peak_limit_step + 2'h1;
        end
      end
      else
      begin
        step_cnt_reg <= step_cnt_reg + SW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Valley-skip up/down counter
  assign above_up   = line_high ? fb_above_up_hi : fb_above_up_lo;
  assign above_down = line_high ? fb_above_down_hi : fb_above_down_lo;
  assign period_end = running && (upd_cnt_reg == UW'(UPDATE_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      upd_cnt_reg <= '0;
    else if (!running || period_end)
      upd_cnt_reg <= '0;
    else
      upd_cnt_reg <= upd_cnt_reg + UW'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seen_up_reg   <= 1'b0;
      seen_down_reg <= 1'b0;
    end
    else if (period_end || !running)
    begin
      seen_up_reg   <= 1'b0;
      seen_down_reg <= 1'b0;
    end
    else
    begin
      seen_up_reg   <= seen_up_reg | above_up;
      seen_down_reg <= seen_down_reg | above_down;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      skip_count <= qr_pkg::SKIP_MIN;
    else if (!running || fb_above_preset)
      skip_count <= qr_pkg::SKIP_MIN;
    else if (period_end)
    begin
      if (seen_down_reg || above_down)
      begin
        if (skip_count != qr_pkg::SKIP_MIN)
          skip_count <= skip_count - 3'h1;
      end
      else if (!(seen_up_reg || above_up))
      begin
        if (skip_count != qr_pkg::SKIP_MAX)
          skip_count <= skip_count + 3'h1;
      end
      else
      begin
        skip_count <= skip_count;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero crossings, ringing suppression, switch on and off
  assign zc_fall   = zc_prev_reg && !zero_cross_input;
  assign ring_done = (ring_cnt_reg == '0);
  assign turn_on   = running && !gate_on && ring_done &&
                     ((zc_count >= skip_count) || off_cnt_reg == OW'(qr_pkg::OFF_MAX_CYC - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      zc_prev_reg <= 1'b0;
    else
      zc_prev_reg <= zero_cross_input;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      zc_count <= 3'h0;
    else if (gate_on)
      zc_count <= 3'h0;
    else if (zc_fall && zc_count != qr_pkg::ZC_MAX)
      zc_count <= zc_count + 3'h1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ring_cnt_reg <= '0;
    else if (gate_on)
      ring_cnt_reg <= zc_above_ring_level ? OW'(qr_pkg::RING_SHORT_CYC) : OW'(qr_pkg::RING_LONG_CYC);
    else if (!ring_done)
      ring_cnt_reg <= ring_cnt_reg - OW'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      off_cnt_reg <= '0;
    else if (gate_on || !running)
      off_cnt_reg <= '0;
    else if (off_cnt_reg != OW'(qr_pkg::OFF_MAX_CYC - 1))
      off_cnt_reg <= off_cnt_reg + OW'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gate_on <= 1'b0;
    else if (gate_on && (cs_above_feedback || !running))
      gate_on <= 1'b0;
    else if (turn_on)
      gate_on <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_period_up;
    period_end && !fb_above_preset && !seen_up_reg && !above_up && !seen_down_reg && !above_down;
  endsequence

  AST_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
    skip_count >= qr_pkg::SKIP_MIN && skip_count <= qr_pkg::SKIP_MAX)
    else $error("skip count out of range");
  AST_UP: assert property (@(posedge clk) disable iff (!rst_n)
    s_period_up |=> skip_count == (($past(skip_count) == 3'h7) ? 3'h7 : $past(skip_count) + 3'h1))
    else $error("count up wrong");
  AST_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
    period_end && !fb_above_preset && seen_down_reg && skip_count > 3'h1 |=> skip_count == $past(skip_count) - 3'h1)
    else $error("count down wrong");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    period_end && !fb_above_preset && seen_up_reg && !seen_down_reg && !above_down |=> $stable(skip_count))
    else $error("hold wrong");
  AST_PRESET: assert property (@(posedge clk) disable iff (!rst_n)
    fb_above_preset |=> skip_count == 3'h1)
    else $error("preset not applied");
  AST_MIDPERIOD: assert property (@(posedge clk) disable iff (!rst_n)
    !period_end && !fb_above_preset && running |=> $stable(skip_count))
    else $error("count changed mid period");
  AST_ZC_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    gate_on |=> zc_count == 3'h0)
    else $error("zero-cross count not cleared");
  AST_RING: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(gate_on) |-> !ring_done)
    else $error("ringing suppression not armed at switch-off");
  AST_RING_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    !gate_on && !ring_done |=> !gate_on)
    else $error("switch-on during ringing suppression");
  AST_START: assert property (@(posedge clk) disable iff (!rst_n)
    phase_reg == qr_pkg::ST_WAIT && supply_turn_on_threshold |=> !charge_enable && phase_reg == qr_pkg::ST_SOFT)
    else $error("start-up wrong");
  AST_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    phase_reg == qr_pkg::ST_SOFT && step_cnt_reg != SW'(STEP_CYCLES - 1) |=> $stable(peak_limit_step))
    else $error("soft-start step early");
endmodule

// File: rtl/qr_pkg.sv
// Package: constants for the quasi-resonant valley-skip and soft-start core
// Assumes a 50 MHz clock; all timing counts derive from it
package qr_pkg;
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned UPDATE_MS       = 48;
  localparam int unsigned UPDATE_CYCLES   = CLK_HZ / 1000 * UPDATE_MS;
  localparam int unsigned SOFTSTART_MS    = 12;
  localparam int unsigned SOFTSTART_STEPS = 4;
  localparam int unsigned STEP_CYCLES     = CLK_HZ / 1000 * SOFTSTART_MS / SOFTSTART_STEPS;
  localparam int unsigned RING_LONG_US    = 5;
  localparam int unsigned RING_SHORT_US   = 2;
  localparam int unsigned RING_LONG_CYC   = CLK_HZ / 1000000 * RING_LONG_US;
  localparam int unsigned RING_SHORT_CYC  = CLK_HZ / 1000000 * RING_SHORT_US;
  localparam int unsigned OFF_MAX_US      = 50;
  localparam int unsigned OFF_MAX_CYC     = CLK_HZ / 1000000 * OFF_MAX_US;
  localparam logic [2:0]  SKIP_MIN        = 3'h1;
  localparam logic [2:0]  SKIP_MAX        = 3'h7;
  localparam logic [2:0]  ZC_MAX          = 3'h7;
  localparam logic [1:0]  LIMIT_FINAL     = 2'h3;
  // Peak limit step codes: 0 = 0.32 V ... 3 = 1 V
  localparam logic [7:0]  LIMIT_MV0       = 8'h20;
  localparam logic [7:0]  LIMIT_MV_FINAL  = 8'h64;
  typedef enum logic [1:0] {ST_WAIT, ST_SOFT, ST_RUN} phase_e;
endpackage

// File: verif/qr_front_end.sv
// Front-end model: feedback comparators, zero-crossing ringing, current sense
// Assumes the bench sets the feedback level code and crossings per off time
`timescale 1ns/1ns
module qr_front_end (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       gate_on,
  input  wire logic       line_high,
  input  wire logic [1:0] fb_lvl,
  input  wire logic [3:0] zc_n,
  output logic            fb_above_up_lo,
  output logic            fb_above_up_hi,
  output logic            fb_above_down_lo,
  output logic            fb_above_down_hi,
  output logic            fb_above_preset,
  output logic            zero_cross_input,
  output logic            cs_above_feedback
);
  logic [15:0] cnt_reg;
  logic        gate_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Unused line set shows the opposite level
  assign fb_above_up_hi    = line_high ? fb_lvl >= 2'h1 : fb_lvl < 2'h1;
  assign fb_above_down_hi  = line_high ? fb_lvl >= 2'h2 : fb_lvl < 2'h2;
  assign fb_above_up_lo    = line_high ? fb_lvl < 2'h1 : fb_lvl >= 2'h1;
  assign fb_above_down_lo  = line_high ? fb_lvl < 2'h2 : fb_lvl >= 2'h2;
  assign fb_above_preset   = fb_lvl == 2'h3;
  // Ringing: one crossing per 100 cycles off, zc_n of them
  assign zero_cross_input  = !gate_on && (cnt_reg / 16'h0064) < {12'h000, zc_n} && (cnt_reg % 16'h0064) < 16'h0032;
  // On time counted from the edge after switch-on
  assign cs_above_feedback = gate_on && gate_reg && cnt_reg >= 16'h000a;
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since last gate edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg  <= 16'h0000;
      gate_reg <= 1'b0;
    end
    else
    begin
      gate_reg <= gate_on;
      cnt_reg  <= (gate_on != gate_reg) ? 16'h0000 : cnt_reg + 16'h0001;
    end
  end
endmodule

// File: verif/tb_top.sv
// Testbench: skip count rows, soft-start steps, switch timing, reset
// Assumes qr_pkg, the core and the front-end model are compiled first
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
  typedef struct {logic ln; logic [1:0] lv; logic [2:0] ex;} row_s;
  logic       clk = 1'b0, rst_n = 1'b0, sup = 1'b0, line = 1'b0, ring_hi = 1'b0, mon = 1'b0, gate_prev = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic [3:0] zc_n = 4'h7;
  logic       up_lo, up_hi, dn_lo, dn_hi, pre, zc, cs, gate, chg;
  logic [1:0] step;
  logic [2:0] skip, zcc;
  logic [2:0] skip_prev = 3'h1;
  logic       seen_on = 1'b0;
  int         err_total = 0, total_checks = 0, off_cnt = 0;
  row_s       rows [14] = '{'{1'b0, 2'h0, 3'h2}, '{1'b1, 2'h0, 3'h3}, '{1'b0, 2'h0, 3'h4}, '{1'b1, 2'h0, 3'h5},
                           '{1'b0, 2'h0, 3'h6}, '{1'b0, 2'h0, 3'h7}, '{1'b1, 2'h0, 3'h7}, '{1'b0, 2'h1, 3'h7},
                           '{1'b1, 2'h1, 3'h7}, '{1'b0, 2'h2, 3'h6}, '{1'b1, 2'h2, 3'h5}, '{1'b1, 2'h1, 3'h5},
                           '{1'b0, 2'h3, 3'h1}, '{1'b1, 2'h2, 3'h1}};
  always #10 clk = ~clk;
  qr_front_end i_fe (.clk(clk), .rst_n(rst_n), .gate_on(gate), .line_high(line), .fb_lvl(lvl), .zc_n(zc_n),
    .fb_above_up_lo(up_lo), .fb_above_up_hi(up_hi), .fb_above_down_lo(dn_lo), .fb_above_down_hi(dn_hi),
    .fb_above_preset(pre), .zero_cross_input(zc), .cs_above_feedback(cs));
  qr_valley_skip_softstart #(.UPDATE_CYCLES(40), .STEP_CYCLES(20)) i_dut (.clk(clk), .rst_n(rst_n),
    .supply_turn_on_threshold(sup), .line_high(line), .fb_above_up_lo(up_lo), .fb_above_up_hi(up_hi),
    .fb_above_down_lo(dn_lo), .fb_above_down_hi(dn_hi), .fb_above_preset(pre), .zero_cross_input(zc),
    .zc_above_ring_level(ring_hi), .cs_above_feedback(cs), .gate_on(gate), .charge_enable(chg),
    .peak_limit_step(step), .skip_count(skip), .zc_count(zcc));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Switch-on monitor
  always @(posedge clk)
  begin
    #1;
    if (mon && gate && !gate_prev && zc_n == 4'h0)
      `CHK("max_off", 1'b1, off_cnt >= qr_pkg::OFF_MAX_CYC - 3 && off_cnt <= qr_pkg::OFF_MAX_CYC + 1)
    else if (mon && gate && !gate_prev)
    begin
      `CHK("zc_vs_skip", 1'b1, zcc >= skip_prev)
      if (seen_on)
        `CHK("ring_block", 1'b1, off_cnt >= (ring_hi ? qr_pkg::RING_SHORT_CYC : qr_pkg::RING_LONG_CYC) - 2)
    end
    seen_on = seen_on | gate;
    off_cnt = gate ? 0 : off_cnt + 1;
    gate_prev = gate;
    skip_prev = skip;
  end
  initial
  begin
    #400_000;
    err_total++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    @(posedge clk);
    #1 `CHK("reset", {1'b0, 1'b1, 2'h0, 3'h1, 3'h0}, {gate, chg, step, skip, zcc})
    @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (20) @(posedge clk);
    #1 `CHK("gate_wait", 1'b0, gate)
    `CHK("charge_wait", 1'b1, chg)
    sup = 1'b1;
    line = rows[0].ln;
    lvl = rows[0].lv;
    @(posedge clk);
    #1 `CHK("charge", 1'b0, chg)
    mon = 1'b1;
    fork
      for (int k = 0; k < 4; k++)
      begin
        repeat (k == 0 ? 9 : 20) @(posedge clk);
        #1 `CHK("soft_step", k[1:0], step)
      end
      foreach (rows[r])
      begin
        repeat (40) @(posedge clk);
        #1 `CHK("skip", rows[r].ex, skip)
        if (r < 13)
        begin
          line = rows[r + 1].ln;
          lvl = rows[r + 1].lv;
        end
        ring_hi = (r > 6);
      end
    join
    `CHK("soft_final", 2'h3, step)
    // Sticky flags: a short excursion must decide the whole period
    lvl = 2'h1;
    repeat (5) @(posedge clk);
    #1 lvl = 2'h0;
    repeat (35) @(posedge clk);
    #1 `CHK("sticky_up", 3'h1, skip)
    repeat (40) @(posedge clk);
    #1 `CHK("skip_inc", 3'h2, skip)
    lvl = 2'h2;
    repeat (3) @(posedge clk);
    #1 lvl = 2'h0;
    repeat (37) @(posedge clk);
    #1 `CHK("sticky_down", 3'h1, skip)
    // No crossings per off time: switch-on must come from the maximum off interval
    @(posedge gate);
    @(posedge clk);
    #1 zc_n = 4'h0;
    repeat (6000) @(posedge clk);
    @(posedge gate);
    @(posedge clk);
    #1 zc_n = 4'h7;
    repeat (2000) @(posedge clk);
    #1 rst_n = 1'b0;
    mon = 1'b0;
    #1 `CHK("reset_mid", {1'b0, 1'b1, 2'h0, 3'h1, 3'h0}, {gate, chg, step, skip, zcc})
    results();
  end
endmodule
